// >>> src/epm_monitor.sv
// Engine protection monitor: threshold persistence, masking and service
`timescale 1ns/1ns
//
// Operation
// - Coolant above maximum for delay: alarm
// - Engine protections wait masking time after start
// - Engine protections idle during start and stop
// - Coolant protection needs coolant measurement acquired
// - Oil temperature above maximum for delay: alarm
// - Battery below second threshold for delay: warning
// - Starter driven suppresses all battery protections
// - Rated 12 V up to 17 V, else 24 V
// - Rating chosen at power-up and key OFF
// - Battery thresholds are percent of rated voltage
// - Battery below first threshold for delay: warning
// - Battery above high threshold for delay: warning
// - First service anomaly after programmed running hours
// - Running hours count however engine was started
// - Service anomaly and count survive power loss
// - Rewriting hour setting clears anomaly, restarts count
// - Each service counter has own action type
// - Second service counter identical to the first
// - Service settings writable only at installer level
// - Oil pressure contact active for delay: alarm
// - Oil pressure below minimum for delay: alarm
module epm_monitor
	import epm_pkg::*;
#(
	parameter int unsigned TICK_CYC = CYC_PER_SEC
) (
	// Clock and reset
	input  wire logic                          sys_clk_in,
	input  wire logic                          arst_n_in,
	// Engine state
	input  wire logic                          engine_running_in,
	input  wire logic                          start_stop_phase_in,
	input  wire logic                          starter_drive_in,
	input  wire logic [DLY_W-1:0]              mask_time_in,
	// Coolant temperature
	input  wire logic [VAL_W-1:0]              cool_temp_in,
	input  wire logic                          cool_acq_in,
	input  wire logic [VAL_W-1:0]              cool_max_in,
	input  wire logic [DLY_W-1:0]              cool_dly_in,
	// Oil temperature
	input  wire logic [VAL_W-1:0]              oil_temp_in,
	input  wire logic                          oil_temp_acq_in,
	input  wire logic [VAL_W-1:0]              oil_temp_max_in,
	input  wire logic [DLY_W-1:0]              oil_temp_dly_in,
	// Oil pressure measurement and contact
	input  wire logic [VAL_W-1:0]              oil_pres_in,
	input  wire logic                          oil_pres_acq_in,
	input  wire logic [VAL_W-1:0]              oil_pres_min_in,
	input  wire logic [DLY_W-1:0]              oil_pres_dly_in,
	input  wire logic                          oil_contact_pin_in,
	input  wire logic                          oil_pressure_contact_function_in,
	input  wire logic [DLY_W-1:0]              contact_dly_in,
	// Battery
	input  wire logic [VAL_W-1:0]              batt_mv_in,
	input  wire logic [PCT_W-1:0]              bat_low2_pct_in,
	input  wire logic [DLY_W-1:0]              bat_low2_dly_in,
	input  wire logic [PCT_W-1:0]              bat_low1_pct_in,
	input  wire logic [DLY_W-1:0]              bat_low1_dly_in,
	input  wire logic [PCT_W-1:0]              bat_high_pct_in,
	input  wire logic [DLY_W-1:0]              bat_high_dly_in,
	input  wire logic                          key_off_pin_in,
	// Service counter settings write
	input  wire logic                          svc_wr_in,
	input  wire logic                          svc_sel_in,
	input  wire logic                          installer_in,
	input  wire logic [HRS_W-1:0]              svc_hours_in,
	input  wire logic [ACT_W-1:0]              svc_action_in,
	// Non-volatile restore
	input  wire logic                          nv_load_in,
	input  wire logic                          nv_sel_in,
	input  wire logic [HRS_W-1:0]              nv_set_in,
	input  wire logic [HRS_W-1:0]              nv_hrs_in,
	input  wire logic [ACT_W-1:0]              nv_action_in,
	input  wire logic                          nv_anom_in,
	// Protection outputs
	output logic                               cool_max_alarm_out,
	output logic                               oil_temp_alarm_out,
	output logic                               bat_low2_warn_out,
	output logic                               bat_low1_warn_out,
	output logic                               bat_high_warn_out,
	output logic                               oil_pres_contact_alarm_out,
	output logic                               oil_pres_meas_alarm_out,
	output logic                               rated_24v_out,
	// Service counter state, to be saved
	output logic [1:0]                         svc_anom_out,
	output logic [1:0][ACT_W-1:0]              svc_action_out,
	output logic [1:0][HRS_W-1:0]              svc_set_out,
	output logic [1:0][HRS_W-1:0]              svc_hrs_out
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Measured battery voltage scaled by one hundred
	function automatic logic [31:0] batt_scaled(input logic [VAL_W-1:0] mv);
		batt_scaled = 32'(mv) * PCT_SCALE;
	endfunction

	// Percentage threshold of the selected rated voltage
	function automatic logic [31:0] pct_ref(input logic [PCT_W-1:0] pct,
		input logic r24);
		pct_ref = 32'(pct) * (r24 ? RATED_24_MV : RATED_12_MV);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and filters

	logic [PIN_W-1:0] pin_s1;
	logic [PIN_W-1:0] pin_s2;
	logic [PIN_W-1:0] pin_s3;
	logic [PIN_W-1:0] pin_val;
	logic             key_prev;
	logic             key_off_edge;

	// Three stages; a level counts once stages two and three agree
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pin_s1  <= '0;
			pin_s2  <= '0;
			pin_s3  <= '0;
			pin_val <= '0;
		end else begin
			pin_s1  <= {key_off_pin_in, oil_contact_pin_in};
			pin_s2  <= pin_s1;
			pin_s3  <= pin_s2;
			for (int i = 0; i < PIN_W; i++) begin
				if (pin_s2[i] == pin_s3[i]) begin
					pin_val[i] <= pin_s3[i];
				end
			end
		end
	end

	// Key OFF/RESET edge
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			key_prev <= 1'b0;
		end else begin
			key_prev <= pin_val[PIN_KEY];
		end
	end

	assign key_off_edge = pin_val[PIN_KEY] && !key_prev;

	////////////////////////////////////////////////////////////////////////
	// One-second tick

	logic [31:0] tick_cnt;
	logic        sec_tick;

	// Divider producing a one-cycle pulse per second
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tick_cnt <= '0;
		end else if (tick_cnt == 32'(TICK_CYC - 1)) begin
			tick_cnt <= '0;
		end else begin
			tick_cnt <= tick_cnt + 32'h0000_0001;
		end
	end

	assign sec_tick = (tick_cnt == 32'(TICK_CYC - 1));

	////////////////////////////////////////////////////////////////////////
	// Engine masking

	logic [DLY_W-1:0] mask_cnt;
	logic             mask_done;
	logic             eng_ok;

	// Seconds since engine start, saturating at the masking time
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mask_cnt <= DLY_ZERO;
		end else if (!engine_running_in) begin
			mask_cnt <= DLY_ZERO;
		end else if (sec_tick && !mask_done) begin
			mask_cnt <= mask_cnt + 16'h0001;
		end
	end

	assign mask_done = (mask_cnt >= mask_time_in);
	// Masked until elapsed, idle in start and stop phases
	assign eng_ok = engine_running_in && mask_done &&
		!start_stop_phase_in;

	////////////////////////////////////////////////////////////////////////
	// Rated battery voltage

	epm_rsel_t rsel;
	logic      rated_24;

	// Selected on the first cycle after reset and at each key OFF
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rsel     <= RS_POWERUP;
			rated_24 <= 1'b0;
		end else begin
			case (rsel)
				RS_POWERUP: begin
					rated_24 <= (batt_mv_in > BATT_SPLIT_MV);
					rsel     <= RS_READY;
				end
				RS_READY: begin
					if (key_off_edge) begin
						rated_24 <= (batt_mv_in > BATT_SPLIT_MV);
					end
				end
				default: begin
					rsel <= RS_POWERUP;
				end
			endcase
		end
	end

	assign rated_24v_out = rated_24;

	////////////////////////////////////////////////////////////////////////
	// Protection conditions

	logic [N_PROT-1:0]            cond;
	logic [N_PROT-1:0][DLY_W-1:0] dly;
	logic [31:0]                  batt_x100;
	logic                         bat_ok;

	assign batt_x100 = batt_scaled(batt_mv_in);
	assign bat_ok    = !starter_drive_in;

	// Condition and delay of each persistence channel
	always_comb begin
		cond[P_COOL] = eng_ok && cool_acq_in &&
			(cool_temp_in > cool_max_in);
		cond[P_OILT] = eng_ok && oil_temp_acq_in &&
			(oil_temp_in > oil_temp_max_in);
		cond[P_BAT2] = bat_ok &&
			(batt_x100 < pct_ref(bat_low2_pct_in, rated_24));
		cond[P_BAT1] = bat_ok &&
			(batt_x100 < pct_ref(bat_low1_pct_in, rated_24));
		cond[P_BATH] = bat_ok &&
			(batt_x100 > pct_ref(bat_high_pct_in, rated_24));
		cond[P_OPC]  = eng_ok && oil_pressure_contact_function_in &&
			pin_val[PIN_OILP];
		cond[P_OPM]  = eng_ok && oil_pres_acq_in &&
			(oil_pres_in < oil_pres_min_in);
		dly[P_COOL]  = cool_dly_in;
		dly[P_OILT]  = oil_temp_dly_in;
		dly[P_BAT2]  = bat_low2_dly_in;
		dly[P_BAT1]  = bat_low1_dly_in;
		dly[P_BATH]  = bat_high_dly_in;
		dly[P_OPC]   = contact_dly_in;
		dly[P_OPM]   = oil_pres_dly_in;
	end

	////////////////////////////////////////////////////////////////////////
	// Persistence timers and latched anomalies

	logic [N_PROT-1:0][DLY_W-1:0] pcnt;
	logic [N_PROT-1:0]            fire;
	logic [N_PROT-1:0]            prot;

	// Any interruption or a zero delay restarts the count
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pcnt <= '0;
		end else begin
			for (int i = 0; i < N_PROT; i++) begin
				if (!cond[i] || dly[i] == DLY_ZERO) begin
					pcnt[i] <= DLY_ZERO;
				end else if (sec_tick && pcnt[i] < dly[i]) begin
					pcnt[i] <= pcnt[i] + 16'h0001;
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < N_PROT; i++) begin
			fire[i] = cond[i] && dly[i] != DLY_ZERO && pcnt[i] >= dly[i];
		end
	end

	// Latched until key OFF/RESET; a new firing wins over the clear
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			prot <= '0;
		end else begin
			prot <= (prot & {N_PROT{!key_off_edge}}) | fire;
		end
	end

	assign cool_max_alarm_out         = prot[P_COOL];
	assign oil_temp_alarm_out         = prot[P_OILT];
	assign bat_low2_warn_out          = prot[P_BAT2];
	assign bat_low1_warn_out          = prot[P_BAT1];
	assign bat_high_warn_out          = prot[P_BATH];
	assign oil_pres_contact_alarm_out = prot[P_OPC];
	assign oil_pres_meas_alarm_out    = prot[P_OPM];

	////////////////////////////////////////////////////////////////////////
	// Service counters

	logic [1:0][HRS_W-1:0] svc_set;
	logic [1:0][HRS_W-1:0] svc_hrs;
	logic [1:0][SEC_W-1:0] svc_sec;
	logic [1:0][ACT_W-1:0] svc_act;
	logic [1:0]            svc_anom;
	logic [1:0]            svc_wr_ok;
	logic [1:0]            svc_nv;

	// Writes only at installer level; restore loads the saved state
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			svc_wr_ok[c] = svc_wr_in && installer_in &&
				(svc_sel_in == c[0]);
			svc_nv[c]    = nv_load_in && (nv_sel_in == c[0]);
		end
	end

	// Settings and running-hour counts, both counters alike
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			svc_set <= '0;
			svc_hrs <= '0;
			svc_sec <= '0;
			svc_act <= '0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (svc_wr_ok[c]) begin
					svc_set[c] <= svc_hours_in;
					svc_act[c] <= svc_action_in;
					svc_hrs[c] <= HRS_ZERO;
					svc_sec[c] <= SEC_ZERO;
				end else if (svc_nv[c]) begin
					svc_set[c] <= nv_set_in;
					svc_act[c] <= nv_action_in;
					svc_hrs[c] <= nv_hrs_in;
					svc_sec[c] <= SEC_ZERO;
				end else if (sec_tick && engine_running_in &&
					svc_set[c] != HRS_ZERO && !svc_anom[c]) begin
					if (svc_sec[c] == SEC_LAST) begin
						svc_sec[c] <= SEC_ZERO;
						svc_hrs[c] <= svc_hrs[c] + 16'h0001;
					end else begin
						svc_sec[c] <= svc_sec[c] + 12'h001;
					end
				end
			end
		end
	end

	// Anomaly raised when hours reach the setting; an installer write clears
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			svc_anom <= '0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (svc_wr_ok[c]) begin
					svc_anom[c] <= 1'b0;
				end else if (svc_nv[c]) begin
					svc_anom[c] <= nv_anom_in;
				end else if (svc_set[c] != HRS_ZERO &&
					svc_hrs[c] >= svc_set[c]) begin
					svc_anom[c] <= 1'b1;
				end
			end
		end
	end

	assign svc_anom_out   = svc_anom;
	assign svc_action_out = svc_act;
	assign svc_set_out    = svc_set;
	assign svc_hrs_out    = svc_hrs;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!arst_n_in);

	chk_cool_cause: assert property (
		$rose(cool_max_alarm_out) |-> $past(eng_ok && cool_acq_in &&
			cool_dly_in != DLY_ZERO && pcnt[P_COOL] >= cool_dly_in))
		else $error("coolant alarm without persisted cause");
	chk_zero_delay: assert property (
		oil_temp_dly_in == DLY_ZERO |=> pcnt[P_OILT] == DLY_ZERO)
		else $error("oil temperature timer runs with zero delay");
	chk_mask_hold: assert property (
		(start_stop_phase_in || !mask_done) |-> !cond[P_OPM] && !cond[P_OPC])
		else $error("oil pressure armed while masked");
	chk_starter_block: assert property (
		starter_drive_in ##1 starter_drive_in |->
			pcnt[P_BAT1] == DLY_ZERO && pcnt[P_BATH] == DLY_ZERO)
		else $error("battery timer runs while starter driven");
	chk_rating_key: assert property (
		rsel == RS_READY && key_off_edge |=>
			rated_24 == ($past(batt_mv_in) > BATT_SPLIT_MV))
		else $error("rating not reselected at key off");
	chk_svc_write: assert property (
		svc_wr_in && installer_in && svc_sel_in |=>
			!svc_anom[1] && svc_hrs[1] == HRS_ZERO)
		else $error("service write did not clear counter");
	chk_svc_locked: assert property (
		svc_wr_in && !installer_in && !nv_load_in |=> $stable(svc_set))
		else $error("service setting changed without installer");
	chk_svc_raise: assert property (
		$rose(svc_anom[0]) |-> $past(nv_load_in) ||
			(svc_set[0] != HRS_ZERO && svc_hrs[0] >= svc_set[0]))
		else $error("service anomaly raised early");
	chk_contact_fn: assert property (
		$rose(oil_pres_contact_alarm_out) |->
			$past(oil_pressure_contact_function_in && pin_val[PIN_OILP]))
		else $error("contact alarm without configured active input");

	cov_cool_alarm: cover property ($rose(cool_max_alarm_out));
	cov_bat_low:    cover property ($rose(bat_low2_warn_out));
	cov_svc_anom:   cover property ($rose(svc_anom[0]));
	cov_rated_24:   cover property ($rose(rated_24));

endmodule

// >>> src/epm_pkg.sv
// Constants and types shared by the engine protection monitor
package epm_pkg;

	// Clock and time base
	localparam int unsigned CLK_HZ       = 250_000_000;
	localparam int unsigned CLK_NS       = 4;
	localparam int unsigned SEC_NS       = 1_000_000_000;
	localparam int unsigned CYC_PER_SEC  = SEC_NS / CLK_NS;
	localparam int unsigned SEC_PER_HOUR = 3600;

	// Data widths
	localparam int unsigned VAL_W = 16;
	localparam int unsigned DLY_W = 16;
	localparam int unsigned PCT_W = 8;
	localparam int unsigned HRS_W = 16;
	localparam int unsigned SEC_W = 12;
	localparam int unsigned ACT_W = 2;
	localparam int unsigned PIN_W = 2;

	// Battery rating selection, millivolts
	localparam logic [VAL_W-1:0] BATT_SPLIT_MV = 16'h4268; // 17000 mV
	localparam logic [31:0]      RATED_12_MV   = 32'h0000_2EE0; // 12000
	localparam logic [31:0]      RATED_24_MV   = 32'h0000_5DC0; // 24000
	localparam logic [31:0]      PCT_SCALE     = 32'h0000_0064; // 100

	// Persistence channel indices
	localparam int unsigned N_PROT = 7;
	localparam int unsigned P_COOL = 0;
	localparam int unsigned P_OILT = 1;
	localparam int unsigned P_BAT2 = 2;
	localparam int unsigned P_BAT1 = 3;
	localparam int unsigned P_BATH = 4;
	localparam int unsigned P_OPC  = 5;
	localparam int unsigned P_OPM  = 6;

	// Synchronised pin indices
	localparam int unsigned PIN_OILP = 0;
	localparam int unsigned PIN_KEY  = 1;

	// Reset values and counter limit
	localparam logic [DLY_W-1:0] DLY_ZERO = 16'h0000;
	localparam logic [HRS_W-1:0] HRS_ZERO = 16'h0000;
	localparam logic [SEC_W-1:0] SEC_ZERO = 12'h000;
	localparam logic [SEC_W-1:0] SEC_LAST = 12'hE0F; // 3599
	localparam logic [ACT_W-1:0] ACT_WARN = 2'h0;

	// Rated battery voltage selection state
	typedef enum logic [0:0] {
		RS_POWERUP,
		RS_READY
	} epm_rsel_t;

endpackage

// >>> verification/epm_plant.sv
// Plant model: sensors, oil pressure contact, key switch, battery
`timescale 1ns/1ns
module epm_plant
	import epm_pkg::*;
(
	// Clock and supply mode
	input  wire logic             sys_clk_in,
	input  wire logic             slow_in,
	// Commanded plant state
	input  wire logic [VAL_W-1:0] cool_tgt_in,
	input  wire logic [VAL_W-1:0] oilt_tgt_in,
	input  wire logic [VAL_W-1:0] oilp_tgt_in,
	input  wire logic [VAL_W-1:0] batt_tgt_in,
	input  wire logic             cont_tgt_in,
	input  wire logic             key_tgt_in,
	// Sensed values and pins
	output logic      [VAL_W-1:0] cool_out,
	output logic      [VAL_W-1:0] oilt_out,
	output logic      [VAL_W-1:0] oilp_out,
	output logic      [VAL_W-1:0] batt_out,
	output logic                  cont_out,
	output logic                  key_out
);
	////////////////////////
	// Known levels before the first edge
	initial begin
		{cool_out, oilt_out, oilp_out, batt_out} = '0;
		{cont_out, key_out} = 2'b00;
	end

	// Sensors and pins follow the plant one cycle late
	always @(posedge sys_clk_in) begin
		cool_out <= cool_tgt_in;
		oilt_out <= oilt_tgt_in;
		oilp_out <= oilp_tgt_in;
		cont_out <= cont_tgt_in;
		key_out  <= key_tgt_in;
	end

	// A weak supply slews 100 mV a cycle instead of stepping
	always @(posedge sys_clk_in) begin
		if (!slow_in || batt_out == batt_tgt_in) begin
			batt_out <= batt_tgt_in;
		end else if (batt_out + 16'h0064 < batt_tgt_in) begin
			batt_out <= batt_out + 16'h0064;
		end else if (batt_out > batt_tgt_in + 16'h0064) begin
			batt_out <= batt_out - 16'h0064;
		end else begin
			batt_out <= batt_tgt_in;
		end
	end
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the engine protection monitor
`timescale 1ns/1ns
module testbench
	import epm_pkg::*;
;
	localparam int unsigned TK    = 4;     // Cycles a second, shortened
	localparam int unsigned LIMIT = 40000; // Cycle ceiling for the run
	localparam logic [DLY_W-1:0] D = 16'h0002; // Delay of every check, s
	typedef struct {
		int unsigned sel;
		logic [15:0] exp;
	} epm_note_t;

	// Bench state
	epm_note_t   notes[$];
	epm_note_t   n;
	event        look;
	int unsigned mismatches = 0;
	int unsigned num_checks = 0;
	int unsigned cyc = 0;
	logic [15:0] v;
	// Design ports
	logic sys_clk_in, arst_n_in, engine_running_in, start_stop_phase_in;
	logic starter_drive_in, cool_acq_in, oil_temp_acq_in, oil_pres_acq_in;
	logic oil_contact_pin_in, oil_pressure_contact_function_in;
	logic key_off_pin_in, svc_wr_in, svc_sel_in, installer_in;
	logic nv_load_in, nv_sel_in, nv_anom_in;
	logic [VAL_W-1:0] cool_temp_in, cool_max_in, oil_temp_in, batt_mv_in;
	logic [VAL_W-1:0] oil_temp_max_in, oil_pres_in, oil_pres_min_in;
	logic [DLY_W-1:0] mask_time_in, cool_dly_in, oil_temp_dly_in;
	logic [DLY_W-1:0] oil_pres_dly_in, contact_dly_in, bat_low2_dly_in;
	logic [DLY_W-1:0] bat_low1_dly_in, bat_high_dly_in;
	logic [PCT_W-1:0] bat_low2_pct_in, bat_low1_pct_in, bat_high_pct_in;
	logic [HRS_W-1:0] svc_hours_in, nv_set_in, nv_hrs_in;
	logic [ACT_W-1:0] svc_action_in, nv_action_in;
	logic cool_max_alarm_out, oil_temp_alarm_out, bat_low2_warn_out;
	logic bat_low1_warn_out, bat_high_warn_out, oil_pres_contact_alarm_out;
	logic oil_pres_meas_alarm_out, rated_24v_out;
	logic [1:0] svc_anom_out;
	logic [1:0][ACT_W-1:0] svc_action_out;
	logic [1:0][HRS_W-1:0] svc_set_out, svc_hrs_out;
	// Plant commands
	logic [VAL_W-1:0] cool_tgt, oilt_tgt, oilp_tgt, batt_tgt;
	logic cont_tgt, key_tgt, slow;

	////////////////////////
	// Plant on the far side of the monitor
	epm_plant u_plant (
		.sys_clk_in, .slow_in(slow), .cool_tgt_in(cool_tgt),
		.oilt_tgt_in(oilt_tgt), .oilp_tgt_in(oilp_tgt),
		.batt_tgt_in(batt_tgt), .cont_tgt_in(cont_tgt), .key_tgt_in(key_tgt),
		.cool_out(cool_temp_in), .oilt_out(oil_temp_in),
		.oilp_out(oil_pres_in), .batt_out(batt_mv_in),
		.cont_out(oil_contact_pin_in), .key_out(key_off_pin_in)
	);

	// Monitor with a short second
	epm_monitor #(.TICK_CYC(TK)) u_dut (.*);

	// Clock, 4 ns period
	initial sys_clk_in = 1'b0;
	always #2 sys_clk_in = ~sys_clk_in;

	////////////////////////
	// Output picked by a note
	function automatic logic [15:0] obs(input int unsigned s);
		logic [6:0] al;
		al = {oil_pres_meas_alarm_out, oil_pres_contact_alarm_out,
			bat_high_warn_out, bat_low1_warn_out, bat_low2_warn_out,
			oil_temp_alarm_out, cool_max_alarm_out};
		case (s)
			7: return {15'h0000, rated_24v_out};
			8, 9: return {15'h0000, svc_anom_out[s-8]};
			10, 11: return svc_set_out[s-10];
			12, 13: return svc_hrs_out[s-12];
			14, 15: return {14'h0000, svc_action_out[s-14]};
			default: return {15'h0000, al[s]};
		endcase
	endfunction

	// Expected firing under a gating mode; engine checks are 0, 1, 5, 6
	function automatic logic gexp(input int unsigned m, k);
		logic eng;
		eng = (k < 2) || (k > 4);
		if (m == 0) return 1'b0;
		return (m == 4) ? eng : !eng;
	endfunction

	// Margin beyond a threshold, 1 to 100
	function automatic logic [15:0] rv();
		return 16'($urandom_range(1, 100));
	endfunction

	task automatic check(input logic [15:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic want(input int unsigned s, input logic [15:0] e);
		notes.push_back('{s, e});
		->look;
	endtask

	task automatic tick(input int unsigned c);
		repeat (c) @(posedge sys_clk_in);
		#1;
	endtask

	task automatic done(input string s);
		$display("test %s done", s);
	endtask

	task automatic finish_test();
		#1;
		$display("checks %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic set_dly(input int unsigned k, input logic [15:0] d);
		case (k)
			0: cool_dly_in = d;
			1: oil_temp_dly_in = d;
			2: bat_low2_dly_in = d;
			3: bat_low1_dly_in = d;
			4: bat_high_dly_in = d;
			5: contact_dly_in = d;
			default: oil_pres_dly_in = d;
		endcase
	endtask

	// Drive the plant into or out of the condition of check k
	task automatic cond(input int unsigned k, input logic on);
		case (k)
			0: cool_tgt = on ? cool_max_in + rv() : 16'h0320;
			1: oilt_tgt = on ? oil_temp_max_in + rv() : 16'h0064;
			2: batt_tgt = on ? 16'h1F40 : 16'h2EE0;
			3: batt_tgt = on ? 16'h2328 : 16'h2EE0;
			4: batt_tgt = on ? 16'h3A98 : 16'h2EE0;
			5: cont_tgt = on;
			default: oilp_tgt = on ? oil_pres_min_in - rv() : 16'h01F4;
		endcase
	endtask

	// Apply or lift a gating mode
	task automatic gate(input int unsigned m, k, input logic on);
		case (m)
			0: set_dly(k, on ? DLY_ZERO : D);
			1: start_stop_phase_in = on;
			3: {cool_acq_in, oil_temp_acq_in, oil_pres_acq_in,
				oil_pressure_contact_function_in} = {4{!on}};
			4: starter_drive_in = on;
			5: engine_running_in = !on;
			default: ;
		endcase
	endtask

	// Key to OFF/RESET and back
	task automatic key_clear();
		key_tgt = 1'b1;
		tick(8);
		key_tgt = 1'b0;
		tick(24);
	endtask

	// Hold a condition, optionally broken once, then look and clear
	task automatic run(input int unsigned k, h1, gap, h2,
		input logic rst, exp);
		if (rst) begin
			engine_running_in = 1'b0;
			tick(TK);
			engine_running_in = 1'b1;
		end
		cond(k, 1'b1);
		tick(h1);
		if (gap > 0) begin
			cond(k, 1'b0);
			tick(gap);
			cond(k, 1'b1);
			tick(h2);
		end
		cond(k, 1'b0);
		tick(8);
		want(k, {15'h0000, exp});
		key_clear();
	endtask

	// Service or restore strobe; one edge passes before the next
	task automatic wr(input logic nv, sel, inst, input logic [15:0] h,
		input logic [1:0] a);
		{svc_sel_in, nv_sel_in} = {2{sel}};
		installer_in = inst;
		{svc_hours_in, nv_set_in, nv_hrs_in} = {3{h}};
		{svc_action_in, nv_action_in} = {2{a}};
		nv_anom_in = nv;
		{nv_load_in, svc_wr_in} = {nv, !nv};
		tick(1);
		{nv_load_in, svc_wr_in} = 2'b00;
		tick(1);
	endtask

	task automatic pwr_reset();
		arst_n_in = 1'b0;
		tick(12);
		arst_n_in = 1'b1;
		tick(2);
	endtask

	////////////////////////
	// Compare each note as its result is ready
	initial begin
		forever begin
			@(look);
			while (notes.size() > 0) begin
				n = notes.pop_front();
				check(obs(n.sel), n.exp);
			end
		end
	end

	// Cut a hang short
	always @(posedge sys_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			mismatches++;
			finish_test();
		end
	end

	// Main sequence
	initial begin
		void'($urandom(32'h06a6));
		{arst_n_in, start_stop_phase_in, starter_drive_in, slow} = 4'h0;
		{engine_running_in, cool_acq_in, oil_temp_acq_in} = 3'b111;
		{oil_pres_acq_in, oil_pressure_contact_function_in} = 2'b11;
		{svc_wr_in, svc_sel_in, installer_in, nv_load_in} = 4'h0;
		{nv_sel_in, nv_anom_in, cont_tgt, key_tgt} = 4'h0;
		{svc_hours_in, nv_set_in, nv_hrs_in} = '0;
		{svc_action_in, nv_action_in} = '0;
		mask_time_in = 16'h0003;
		{cool_max_in, oil_temp_max_in} = {16'h0384, 16'h0096};
		{oil_pres_min_in, batt_tgt} = {16'h012C, 16'h2EE0};
		{cool_tgt, oilt_tgt, oilp_tgt} = {16'h0320, 16'h0064, 16'h01F4};
		{bat_low2_pct_in, bat_low1_pct_in} = {8'h46, 8'h50};
		bat_high_pct_in = 8'h78;
		for (int k = 0; k < 7; k++) set_dly(k, D);
		pwr_reset();
		tick(24);
		want(7, 16'h0000);
		for (int k = 0; k < 7; k++) begin
			run(k, 3, 0, 0, 1'b0, 1'b0);
			run(k, 14, 0, 0, 1'b0, 1'b1);
			run(k, 3, 1, 3, 1'b0, 1'b0);
		end
		done("persistence");
		for (int m = 0; m < 6; m++) begin
			for (int k = 0; k < 7; k++) begin
				gate(m, k, 1'b1);
				run(k, 14, 0, 0, m == 2, gexp(m, k));
				gate(m, k, 1'b0);
				tick(24);
			end
		end
		done("gating");
		slow = 1'b1;
		for (int i = 0; i < 4; i++) begin
			v = (i < 2) ? 16'h4268 + 16'(i) : 16'($urandom_range(9000, 30000));
			batt_tgt = v;
			tick(250);
			key_clear();
			want(7, {15'h0000, v > 16'h4268});
		end
		batt_tgt = 16'h4269;
		tick(250);
		key_clear();
		batt_tgt = 16'h4A38;
		tick(60);
		want(3, 16'h0001);
		want(4, 16'h0000);
		slow = 1'b0;
		batt_tgt = 16'h2EE0;
		key_clear();
		done("rating");
		wr(1'b0, 1'b0, 1'b1, 16'h0001, 2'h2);
		wr(1'b0, 1'b1, 1'b1, 16'h0001, 2'h3);
		wr(1'b0, 1'b0, 1'b0, 16'h0005, 2'h1);
		want(10, 16'h0001);
		want(14, 16'h0002);
		want(15, 16'h0003);
		tick(3600 * TK - 40);
		want(8, 16'h0000);
		tick(80);
		want(8, 16'h0001);
		want(12, 16'h0001);
		want(9, 16'h0001);
		wr(1'b0, 1'b0, 1'b1, 16'h0001, 2'h2);
		want(8, 16'h0000);
		want(12, 16'h0000);
		want(9, 16'h0001);
		batt_tgt = 16'h4E20;
		tick(2);
		pwr_reset();
		want(7, 16'h0001);
		wr(1'b1, 1'b1, 1'b1, 16'h0001, 2'h3);
		want(9, 16'h0001);
		want(13, 16'h0001);
		wr(1'b0, 1'b1, 1'b1, 16'h0000, 2'h0);
		want(9, 16'h0000);
		done("service");
		finish_test();
	end
endmodule
